// ==== hw/serial_host_mgmt_port.sv ====
`include "mgmt_port_params.svh"
// Functional notes
// RULE1: two modes, lightly managed or unmanaged, strapped
// RULE2: managed mode carries everything over serial link
// RULE3: unmanaged accepts eeprom boot load and serial
// RULE4: unmanaged mode: no frames, no interrupts
// RULE5: 8-bit config registers reached only indirectly
// RULE6: host writes index before config access
// RULE7: data write stores byte at indexed register
// RULE8: data read returns indexed register
// RULE9: index: autostep 15, paired 14, address 11:0
// RULE10: paired write: low byte index, high byte next
// RULE11: auto-step allows consecutive accesses without reindexing
// RULE12: auto-step advances address after each access
// RULE13: host writes frame header bytes first
// RULE14: host then writes at least 64 payload bytes
// RULE15: host frame forwarded like any received frame
// RULE16: interrupt host while a frame waits
// RULE17: received frame info precedes payload bytes
// RULE18: host uses frame size to read payload
// RULE19: control frames up to 40 bytes, address 111
// RULE20: accept host control requests on control register
// RULE21: send device control frames to host
// RULE22: memory requests reach counters, tables, frame memory
// RULE23: command is start, address, read/write, data
module serial_host_mgmt_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic mode_unmanaged_strap,
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    output logic link_dout_oe,
    input wire logic boot_cfg_we,
    input wire logic [11:0] boot_cfg_addr,
    input wire logic [7:0] boot_cfg_data,
    input wire logic [11:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data,
    output logic managed_mode,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_sof,
    output logic tx_eof,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] ctl_tx_byte,
    output logic ctl_tx_valid,
    output logic ctl_tx_sof,
    input wire logic [7:0] ctl_rx_byte,
    input wire logic ctl_rx_valid,
    output logic ctl_rx_ready,
    output logic host_irq
);
    // link domain
    mgmt_port_pkg::link_state_t lstate_reg;
    logic [4:0] lcnt_reg;
    logic [2:0] laddr_reg;
    logic lwrite_reg;
    logic [15:0] lshift_reg;
    logic req_tog_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_seen_reg;
    logic ack_new;

    // core domain
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_seen_reg;
    logic ack_tog_reg;
    logic [15:0] rdata_reg;
    logic strap_s1_reg;
    logic strap_s2_reg;
    logic strap_taken_reg;
    logic unmanaged_reg;
    logic [15:0] index_reg;
    logic [7:0] cfg_reg [`CFG_DEPTH];
    logic [15:0] tx_cnt_reg;
    logic [15:0] tx_size_reg;
    logic [5:0] ctl_cnt_reg;
    logic req_new;

    function automatic logic in_bank(input logic [11:0] a);
        in_bank = a < 12'(`CFG_DEPTH);
    endfunction

    function automatic logic [7:0] cfg_at(input logic [11:0] a,
                                          input logic [7:0] v);
        cfg_at = in_bank(a) ? v : 8'h00;
    endfunction

    assign ack_new = ack_s2_reg != ack_seen_reg;

    // serial command: start bit, address, direction, then data
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lstate_reg <= mgmt_port_pkg::l_idle;
            lcnt_reg <= 5'h00;
            laddr_reg <= 3'h0;
            lwrite_reg <= 1'b0;
            lshift_reg <= 16'h0000;
            req_tog_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            link_dout <= 1'b0;
            link_dout_oe <= 1'b0;
        end else begin
            unique case (lstate_reg)
                mgmt_port_pkg::l_idle: begin
                    link_dout_oe <= 1'b0;
                    link_dout <= 1'b0;
                    if (link_din) begin // RULE23
                        lstate_reg <= mgmt_port_pkg::l_addr;
                        lcnt_reg <= 5'h00;
                    end
                end
                mgmt_port_pkg::l_addr: begin
                    laddr_reg <= {laddr_reg[1:0], link_din};
                    lcnt_reg <= lcnt_reg + 5'h01;
                    if (lcnt_reg == 5'(`LINK_ADDR_BITS - 4'h1)) begin
                        lstate_reg <= mgmt_port_pkg::l_rw;
                    end
                end
                mgmt_port_pkg::l_rw: begin
                    lwrite_reg <= link_din;
                    lcnt_reg <= 5'h00;
                    if (link_din) begin
                        lstate_reg <= mgmt_port_pkg::l_data;
                    end else begin
                        req_tog_reg <= ~req_tog_reg;
                        lstate_reg <= mgmt_port_pkg::l_wait;
                    end
                end
                mgmt_port_pkg::l_data: begin
                    lshift_reg <= {lshift_reg[14:0], link_din};
                    lcnt_reg <= lcnt_reg + 5'h01;
                    if (lcnt_reg == `LINK_DATA_BITS - 5'h01) begin
                        req_tog_reg <= ~req_tog_reg;
                        lstate_reg <= mgmt_port_pkg::l_wait;
                    end
                end
                mgmt_port_pkg::l_wait: begin
                    // request fields stay still until the core answers
                    if (ack_new) begin
                        ack_seen_reg <= ack_s2_reg;
                        lcnt_reg <= 5'h00;
                        if (lwrite_reg) begin
                            lstate_reg <= mgmt_port_pkg::l_idle;
                        end else begin
                            lshift_reg <= rdata_reg;
                            lstate_reg <= mgmt_port_pkg::l_out;
                        end
                    end
                end
                mgmt_port_pkg::l_out: begin
                    link_dout_oe <= 1'b1;
                    link_dout <= lshift_reg[15];
                    lshift_reg <= {lshift_reg[14:0], 1'b0};
                    lcnt_reg <= lcnt_reg + 5'h01;
                    if (lcnt_reg == `LINK_DATA_BITS) begin
                        link_dout_oe <= 1'b0;
                        link_dout <= 1'b0;
                        lstate_reg <= mgmt_port_pkg::l_idle;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tog_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end else if (ce) begin
            req_s1_reg <= req_tog_reg;
            req_s2_reg <= req_s1_reg;
        end
    end

    // strap sync runs through reset so the mode is settled at release
    always_ff @(posedge clk) begin
        if (ce) begin
            strap_s1_reg <= mode_unmanaged_strap;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    assign req_new = req_s2_reg != req_seen_reg;

    // mode is caught once after reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_taken_reg <= 1'b0;
            unmanaged_reg <= 1'b0;
            managed_mode <= 1'b0;
        end else if (ce && !strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            unmanaged_reg <= strap_s2_reg; // RULE1
            managed_mode <= !strap_s2_reg;
        end
    end

    // request handshake and read answers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_seen_reg <= 1'b0;
            ack_tog_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else if (ce && req_new && strap_taken_reg) begin
            req_seen_reg <= req_s2_reg;
            ack_tog_reg <= ~ack_tog_reg;
            rdata_reg <= 16'h0000;
            if (!lwrite_reg) begin
                unique case (laddr_reg)
                    `SA_TARGET_INDEX: rdata_reg <= index_reg;
                    `SA_INDIRECT_DATA: rdata_reg <= {8'h00, // RULE8
                        cfg_at(index_reg[11:0],
                               cfg_reg[index_reg[7:0]])};
                    `SA_FRAME_TRANSFER: if (!unmanaged_reg && rx_valid) begin
                        rdata_reg <= {8'h00, rx_byte}; // RULE17
                    end
                    `SA_CONTROL_MESSAGE:
                        if (!unmanaged_reg && ctl_rx_valid) begin
                            rdata_reg <= {8'h00, ctl_rx_byte}; // RULE21
                        end
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    // index register with auto-step
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            index_reg <= `TARGET_INDEX_RESET;
        end else if (ce && req_new && strap_taken_reg) begin
            if (lwrite_reg && laddr_reg == `SA_TARGET_INDEX) begin
                index_reg <= lshift_reg & `IDX_WRITABLE_MASK; // RULE9
            end else if (laddr_reg == `SA_INDIRECT_DATA &&
                         index_reg[`IDX_AUTO_STEP_BIT]) begin
                // RULE11 RULE12
                index_reg[11:0] <= index_reg[11:0] +
                    ((lwrite_reg && index_reg[`IDX_PAIRED_WRITE_BIT]) ?
                     12'h002 : 12'h001);
            end
        end
    end

    // configuration bank, written through index and data, and by boot load in unmanaged mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `CFG_DEPTH; i++) begin
                cfg_reg[i] <= `CFG_RESET;
            end
        end else if (ce) begin
            if (req_new && strap_taken_reg && lwrite_reg &&
                laddr_reg == `SA_INDIRECT_DATA) begin
                if (in_bank(index_reg[11:0])) begin
                    cfg_reg[index_reg[7:0]] <= lshift_reg[7:0]; // RULE5 RULE7
                end
                if (index_reg[`IDX_PAIRED_WRITE_BIT] &&
                    in_bank(index_reg[11:0] + 12'h001)) begin
                    cfg_reg[8'(index_reg[7:0] + 8'h01)] <=
                        lshift_reg[15:8]; // RULE10
                end
            end else if (boot_cfg_we && unmanaged_reg && strap_taken_reg &&
                         in_bank(boot_cfg_addr)) begin
                cfg_reg[boot_cfg_addr[7:0]] <= boot_cfg_data; // RULE3
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rd_data <= 8'h00;
        end else if (ce) begin
            cfg_rd_data <= cfg_at(cfg_rd_addr, cfg_reg[cfg_rd_addr[7:0]]);
        end
    end

    // host frame transmit: header bytes, then payload of stated size
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_cnt_reg <= 16'h0000;
            tx_size_reg <= 16'h0000;
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
            tx_sof <= 1'b0;
            tx_eof <= 1'b0;
        end else if (ce) begin
            tx_valid <= 1'b0;
            tx_sof <= 1'b0;
            tx_eof <= 1'b0;
            if (req_new && strap_taken_reg && lwrite_reg && !unmanaged_reg &&
                laddr_reg == `SA_FRAME_TRANSFER) begin // RULE2 RULE4
                tx_byte <= lshift_reg[7:0];
                tx_valid <= 1'b1; // RULE15
                tx_sof <= tx_cnt_reg == 16'h0000;
                if (tx_cnt_reg == 16'h0000) begin
                    tx_size_reg[7:0] <= lshift_reg[7:0];
                end
                if (tx_cnt_reg == 16'h0001) begin
                    tx_size_reg[15:8] <= lshift_reg[7:0];
                end
                if (tx_cnt_reg >= `TX_HDR_BYTES &&
                    tx_cnt_reg == tx_size_reg + `TX_HDR_BYTES - 16'h0001) begin
                    tx_eof <= 1'b1;
                    tx_cnt_reg <= 16'h0000;
                end else begin
                    tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                end
            end
        end
    end

    // control frame transmit, capped at its longest length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_cnt_reg <= 6'h00;
            ctl_tx_byte <= 8'h00;
            ctl_tx_valid <= 1'b0;
            ctl_tx_sof <= 1'b0;
        end else if (ce) begin
            ctl_tx_valid <= 1'b0;
            ctl_tx_sof <= 1'b0;
            if (req_new && strap_taken_reg) begin
                if (lwrite_reg && !unmanaged_reg &&
                    laddr_reg == `SA_CONTROL_MESSAGE) begin
                    if (ctl_cnt_reg < `CTL_MAX_BYTES) begin // RULE19
                        ctl_tx_byte <= lshift_reg[7:0];
                        ctl_tx_valid <= 1'b1; // RULE20 RULE22
                        ctl_tx_sof <= ctl_cnt_reg == 6'h00;
                        ctl_cnt_reg <= ctl_cnt_reg + 6'h01;
                    end
                end else begin
                    ctl_cnt_reg <= 6'h00;
                end
            end
        end
    end

    // receive pops and host interrupt
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_ready <= 1'b0;
            ctl_rx_ready <= 1'b0;
            host_irq <= 1'b0;
        end else if (ce) begin
            rx_ready <= req_new && strap_taken_reg && !lwrite_reg &&
                !unmanaged_reg && rx_valid &&
                laddr_reg == `SA_FRAME_TRANSFER;
            ctl_rx_ready <= req_new && strap_taken_reg && !lwrite_reg &&
                !unmanaged_reg && ctl_rx_valid &&
                laddr_reg == `SA_CONTROL_MESSAGE;
            host_irq <= strap_taken_reg && !unmanaged_reg &&
                (rx_valid || ctl_rx_valid); // RULE16 RULE4
        end
    end
endmodule

// ==== hw/mgmt_port_params.svh ====
`ifndef MGMT_PORT_PARAMS_SVH
`define MGMT_PORT_PARAMS_SVH

// serial register addresses
`define SA_TARGET_INDEX 3'h0
`define SA_INDIRECT_DATA 3'h2
`define SA_FRAME_TRANSFER 3'h3
`define SA_CONTROL_MESSAGE 3'h7

// target_index field positions
`define IDX_AUTO_STEP_BIT 15
`define IDX_PAIRED_WRITE_BIT 14
`define IDX_ADDR_MSB 11
`define IDX_WRITABLE_MASK 16'hcfff
`define TARGET_INDEX_RESET 16'h0000

// configuration storage
`define CFG_ADDR_W 12
`define CFG_DEPTH 256
`define CFG_IDX_W 8
`define CFG_RESET 8'h00

// frame layout
`define TX_HDR_BYTES 16'h0004
`define CTL_MAX_BYTES 6'h28

// serial command lengths in link clocks
`define LINK_ADDR_BITS 4'h3
`define LINK_DATA_BITS 5'h10

`endif

// ==== hw/mgmt_port_pkg.sv ====
package mgmt_port_pkg;
    typedef enum logic [2:0] {
        l_idle,
        l_addr,
        l_rw,
        l_data,
        l_wait,
        l_out
    } link_state_t;
endpackage

// ==== verification/serial_host_mgmt_port_properties.sv ====
module serial_host_mgmt_port_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic link_dout_oe,
    input wire logic [11:0] cfg_rd_addr,
    input wire logic [7:0] cfg_rd_data,
    input wire logic managed_mode,
    input wire logic tx_valid,
    input wire logic tx_sof,
    input wire logic tx_eof,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic ctl_tx_valid,
    input wire logic ctl_tx_sof,
    input wire logic ctl_rx_valid,
    input wire logic host_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_cause;
    assign irq_cause = managed_mode && (rx_valid || ctl_rx_valid);
    // sixteen answer bits, then the line is let go
    sequence read_burst;
        link_dout_oe [*8] ##1 link_dout_oe [*8] ##1 !link_dout_oe;
    endsequence
    a_irq_tracks_wait: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(ce) |-> host_irq == $past(irq_cause))
        else $error("host_irq does not follow waiting bytes");
    a_unmanaged_no_frames: assert property (
        @(posedge clk) disable iff (!nrst)
        !managed_mode |-> !tx_valid && !ctl_tx_valid && !host_irq)
        else $error("frame traffic or irq in unmanaged mode");
    a_tx_marks_valid: assert property (
        @(posedge clk) disable iff (!nrst)
        tx_sof || tx_eof |-> tx_valid)
        else $error("tx frame mark without byte");
    a_tx_byte_pulse: assert property (
        @(posedge clk) disable iff (!nrst)
        tx_valid |=> !tx_valid)
        else $error("tx byte valid longer than one cycle");
    a_ctl_sof_valid: assert property (
        @(posedge clk) disable iff (!nrst)
        ctl_tx_sof |-> ctl_tx_valid)
        else $error("control start without byte");
    a_rx_take_pulse: assert property (
        @(posedge clk) disable iff (!nrst)
        rx_ready |-> managed_mode ##1 !rx_ready)
        else $error("rx_ready not a managed one cycle pulse");
    a_high_cfg_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        cfg_rd_addr[11:8] != 4'h0 && ce |=> cfg_rd_data == 8'h00)
        else $error("config read above bank not zero");
    a_read_burst_len: assert property (
        @(posedge link_clk) disable iff (!nrst)
        $rose(link_dout_oe) |-> read_burst)
        else $error("read answer not sixteen link clocks");
endmodule

bind serial_host_mgmt_port serial_host_mgmt_port_properties props_i (
    .clk, .nrst, .ce, .link_clk, .link_dout_oe, .cfg_rd_addr, .cfg_rd_data,
    .managed_mode, .tx_valid, .tx_sof, .tx_eof, .rx_valid, .rx_ready,
    .ctl_tx_valid, .ctl_tx_sof, .ctl_rx_valid, .host_irq
);

// ==== verification/mgmt_host_model.sv ====
module mgmt_host_model (
    output logic link_clk,
    output logic link_din,
    input wire logic link_dout,
    input wire logic link_dout_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands low between commands
    initial begin
        link_clk = 1'b0;
        link_din = 1'b0;
    end
    task automatic tick(input logic b);
        link_din = b;
        #6 link_clk = 1'b1;
        #6 link_clk = 1'b0;
    endtask
    task automatic cmd(input logic [2:0] a, input logic wr,
        input logic [15:0] d, output logic [15:0] q);
        int n;
        q = 16'h0000;
        tick(1'b1);
        for (n = 2; n >= 0; n--) tick(a[n]);
        tick(wr);
        if (wr) for (n = 15; n >= 0; n--) tick(d[n]);
        n = 0;
        while (wr ? n < 20 : !link_dout_oe && n < 40) begin
            tick(1'b0);
            n++;
        end
        if (!wr) for (n = 0; n < 16; n++) begin
            q = {q[14:0], link_dout};
            tick(1'b0);
        end
        tick(1'b0);
        tick(1'b0);
    endtask
endmodule

// ==== verification/serial_host_mgmt_port_tb.sv ====
module serial_host_mgmt_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, strap, link_clk, link_din, link_dout, link_dout_oe;
    logic boot_we, irq, managed, tx_valid, tx_sof, tx_eof, rx_ready, ce;
    logic ctl_tx_valid, ctl_tx_sof, ctl_rx_ready;
    logic [11:0] boot_addr, cfg_addr;
    logic [7:0] boot_data, cfg_data, tx_byte, ctl_tx_byte, ctl_last;
    logic [7:0] rxm [8];
    logic [7:0] tx_q [$];
    logic [15:0] q, c;
    int errors, checks_done, cyc, ri, ci, rx_n, ctl_n, ctl_cnt, ctl_sof;
    int sof_at, eof_at;
    serial_host_mgmt_port serial_host_mgmt_port_i (
        .clk(clk), .nrst(nrst), .ce(ce), .mode_unmanaged_strap(strap),
        .link_clk(link_clk), .link_din(link_din), .link_dout(link_dout),
        .link_dout_oe(link_dout_oe), .boot_cfg_we(boot_we),
        .boot_cfg_addr(boot_addr), .boot_cfg_data(boot_data),
        .cfg_rd_addr(cfg_addr), .cfg_rd_data(cfg_data),
        .managed_mode(managed), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_sof(tx_sof), .tx_eof(tx_eof), .rx_byte(rxm[ri[2:0]]),
        .rx_valid(ri < rx_n), .rx_ready(rx_ready),
        .ctl_tx_byte(ctl_tx_byte), .ctl_tx_valid(ctl_tx_valid),
        .ctl_tx_sof(ctl_tx_sof), .ctl_rx_byte(rxm[ci[2:0]] ^ 8'h5a),
        .ctl_rx_valid(ci < ctl_n), .ctl_rx_ready(ctl_rx_ready),
        .host_irq(irq)
    );
    mgmt_host_model host_i (
        .link_clk(link_clk), .link_din(link_din), .link_dout(link_dout),
        .link_dout_oe(link_dout_oe)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (tx_valid) tx_q.push_back(tx_byte);
        if (tx_sof) sof_at = tx_q.size();
        if (tx_eof) eof_at = tx_q.size();
        if (ctl_tx_valid) ctl_cnt++;
        if (ctl_tx_sof) ctl_sof = ctl_cnt;
        if (ctl_tx_valid) ctl_last = ctl_tx_byte;
        if (cyc == 30000) begin
            errors++;
            give_verdict();
        end
    end
    // switch side steps to the next byte once one is taken
    always @(negedge clk) begin
        if (rx_ready) ri++;
        if (ctl_rx_ready) ci++;
    end
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        host_i.cmd(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [2:0] a);
        host_i.cmd(a, 1'b0, 16'h0000, q);
    endtask
    task automatic cfg(input logic [11:0] a);
        @(negedge clk) cfg_addr = a;
        @(posedge clk);
        @(negedge clk) c = {8'h00, cfg_data};
    endtask
    task automatic do_reset(input logic s);
        @(negedge clk) nrst = 1'b0;
        strap = s;
        ri = 0;
        ci = 0;
        rx_n = 0;
        ctl_n = 0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
    endtask
    task automatic t_config();
        int i;
        check("mode", {15'h0000, managed}, 16'h0001);
        wr(3'h0, 16'h3010);
        rd(3'h0);
        check("index", q, 16'h0010);
        wr(3'h2, 16'hff77);
        cfg(12'h010);
        check("cfg010", c, 16'h0077);
        cfg(12'h011);
        check("cfg011", c, 16'h0000);
        rd(3'h2);
        check("data", q, 16'h0077);
        wr(3'h0, 16'h4020);
        wr(3'h2, 16'hbbaa);
        cfg(12'h020);
        check("pair lo", c, 16'h00aa);
        cfg(12'h021);
        check("pair hi", c, 16'h00bb);
        wr(3'h0, 16'h8030);
        for (i = 0; i < 3; i++) wr(3'h2, 16'h0010 + 16'(i));
        rd(3'h0);
        check("step idx", q, 16'h8033);
        wr(3'h0, 16'h8030);
        for (i = 0; i < 3; i++) begin
            rd(3'h2);
            check("step rd", q, 16'h0010 + 16'(i));
        end
        wr(3'h0, 16'hc040);
        wr(3'h2, 16'h2211);
        rd(3'h0);
        check("pair step", q, 16'hc042);
        wr(3'h1, 16'h1234);
        rd(3'h1);
        check("unmapped", q, 16'h0000);
        cfg(12'h100);
        check("cfg100", c, 16'h0000);
        // with the enable low the read port must hold its old value
        @(negedge clk) ce = 1'b0;
        cfg(12'h010);
        check("ce hold", c, 16'h0000);
        ce = 1'b1;
    endtask
    task automatic t_tx();
        logic [7:0] hdr [4];
        int k;
        hdr = '{8'h40, 8'h00, 8'h02, 8'h00};
        for (k = 0; k < 68; k++) begin
            wr(3'h3, {8'h00, k < 4 ? hdr[k] : 8'(k)});
        end
        repeat (5) @(negedge clk);
        check("tx n", 16'(tx_q.size()), 16'h0044);
        check("tx sof", 16'(sof_at), 16'h0001);
        check("tx eof", 16'(eof_at), 16'h0044);
        for (k = 0; k < 68; k++) begin
            check("tx b", {8'h00, tx_q[k]},
                  {8'h00, k < 4 ? hdr[k] : 8'(k)});
        end
    endtask
    task automatic t_rx();
        logic [7:0] info [4];
        int i, n;
        rxm = '{8'h08, 8'h03, 8'h00, 8'h0a, 8'hd1, 8'hd2, 8'hd3, 8'he4};
        @(negedge clk) rx_n = 7;
        repeat (3) @(negedge clk);
        check("irq", {15'h0000, irq}, 16'h0001);
        for (i = 0; i < 4; i++) begin
            rd(3'h3);
            info[i] = q[7:0];
            check("rx info", q, {8'h00, rxm[i]});
        end
        n = {info[2], info[1]};
        for (i = 0; i < n; i++) begin
            rd(3'h3);
            check("rx data", q, {8'h00, rxm[4 + i]});
        end
        repeat (3) @(negedge clk);
        check("irq off", {15'h0000, irq}, 16'h0000);
    endtask
    task automatic t_ctl();
        int i;
        @(negedge clk) ctl_n = 2;
        repeat (3) @(negedge clk);
        check("ctl irq", {15'h0000, irq}, 16'h0001);
        for (i = 0; i < 2; i++) begin
            rd(3'h7);
            check("ctl rx", q, {8'h00, rxm[i] ^ 8'h5a});
        end
        for (i = 0; i < 41; i++) wr(3'h7, {8'h00, 8'(i)});
        repeat (5) @(negedge clk);
        check("ctl n", 16'(ctl_cnt), 16'h0028);
        check("ctl sof", 16'(ctl_sof), 16'h0001);
        check("ctl last", {8'h00, ctl_last}, 16'h0027);
    endtask
    task automatic t_unmanaged();
        do_reset(1'b1);
        check("mode", {15'h0000, managed}, 16'h0000);
        @(negedge clk) boot_addr = 12'h050;
        boot_data = 8'h9c;
        boot_we = 1'b1;
        @(negedge clk) boot_we = 1'b0;
        cfg(12'h050);
        check("boot cfg", c, 16'h009c);
        wr(3'h0, 16'h0060);
        wr(3'h2, 16'h0033);
        cfg(12'h060);
        check("ser cfg", c, 16'h0033);
        @(negedge clk) rx_n = 7;
        repeat (3) @(negedge clk);
        check("no irq", {15'h0000, irq}, 16'h0000);
        rd(3'h3);
        check("no rx", q, 16'h0000);
        wr(3'h3, 16'h0055);
        repeat (5) @(negedge clk);
        check("no tx", 16'(tx_q.size()), 16'h0044);
    endtask
    initial begin
        nrst = 1'b0;
        strap = 1'b0;
        ce = 1'b1;
        boot_we = 1'b0;
        boot_addr = 12'h000;
        boot_data = 8'h00;
        cfg_addr = 12'h000;
        rxm = '{default: 8'h00};
        do_reset(1'b0);
        t_config();
        t_tx();
        t_rx();
        t_ctl();
        t_unmanaged();
        give_verdict();
    end
endmodule
